// ### rtl/cmpc_top.sv
// control register bank applying codec mutes, de-emphasis, powerdowns and dac port clocking
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_defines.svh"

// Function
// - global soft mute bit mutes all DACs
// - powerdown mutes abruptly, not by soft ramp
// - ADC right and left mute bits
// - both-mute bit mutes both ADC channels
// - per-channel de-emphasis select bits 8:6
// - de-emphasis-all bit covers every DAC
// - global DAC powerdown overrides channel disables
// - powerdown clears filter history, keeps registers
// - filters reinitialise after global powerdown clears
// - ADC disable holds filters reset, reinit after
// - per-channel DAC disable bits 3:1
// - clearing channel disable reinitialises its filters
// - reference powerdown bit powers down chip references
// - master select makes frame, bit clocks outputs
// - master clocks derived by selected ratio
// - per-channel soft mute bits 5:3
module cmpc_top
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire cmpc_pkg::cmpc_ctrl_s i_ctrl,
   output logic [8:0] o_rd_data,
   output logic [2:0] o_dac_soft_mute,
   output logic o_dac_abrupt_mute,
   output logic [2:0] o_dac_channel_select_a,
   output logic [2:0] o_dac_power_down,
   output logic [2:0] o_dac_filter_reset,
   output logic o_adc_left_mute,
   output logic o_adc_right_mute,
   output logic o_adc_power_down,
   output logic o_adc_filter_reset,
   output logic o_reference_powerdown,
   input wire logic i_dac_frame_clock,
   output logic o_dac_frame_clock,
   output logic o_dac_frame_clock_oe,
   input wire logic i_dac_bit_clock,
   output logic o_dac_bit_clock,
   output logic o_dac_bit_clock_oe,
   output logic o_frame_clock_in_use,
   output logic o_bit_clock_in_use
);

   cmpc_pkg::cmpc_state_s state_reg;
   cmpc_pkg::cmpc_state_s state_next;

   // decoded control bits
   logic dac_global_soft_mute;
   logic channel_select_a_all_channels;
   logic dac_global_powerdown;
   logic [2:0] dac_channel_soft_mute;
   logic [2:0] channel_select_a;
   logic adc_disable;
   logic [2:0] dac_channel_disable;
   logic reference_powerdown;
   logic dac_port_master_select;
   cmpc_pkg::cmpc_ratio_e dac_clock_ratio;
   logic adc_right_mute;
   logic adc_left_mute;
   logic adc_both_mute;
   logic [2:0] dac_down;
   logic [9:0] frame_len;
   logic [3:0] bit_len;
   logic [3:0] dac_reinit_next [3];
   logic dac_reinit_live [3];
   logic wr_dac_mute_channel_select_a_power;
   logic wr_channel_select_a_channel_control;
   logic wr_power_and_port_control;
   logic wr_adc_mute_control;

   // field extraction from the held registers
   assign dac_global_soft_mute =
      state_reg.dac_mute_channel_select_a_power_reg[`CMPC_BIT_DAC_GLOBAL_SOFT_MUTE];
   assign channel_select_a_all_channels =
      state_reg.dac_mute_channel_select_a_power_reg[`CMPC_BIT_CHANNEL_SELECT_A_ALL_CHANNELS];
   assign dac_global_powerdown =
      state_reg.dac_mute_channel_select_a_power_reg[`CMPC_BIT_DAC_GLOBAL_POWERDOWN];
   assign dac_channel_soft_mute =
      state_reg.channel_select_a_channel_control_reg[`CMPC_LSB_DAC_CHANNEL_SOFT_MUTE +: 3];
   assign channel_select_a =
      state_reg.channel_select_a_channel_control_reg[`CMPC_LSB_CHANNEL_SELECT_A +: 3];
   assign adc_disable =
      state_reg.power_and_port_control_reg[`CMPC_BIT_ADC_DISABLE];
   assign dac_channel_disable =
      state_reg.power_and_port_control_reg[`CMPC_LSB_DAC_CHANNEL_DISABLE +: 3];
   assign reference_powerdown =
      state_reg.power_and_port_control_reg[`CMPC_BIT_REFERENCE_POWERDOWN];
   assign dac_port_master_select =
      state_reg.power_and_port_control_reg[`CMPC_BIT_DAC_PORT_MASTER_SELECT];
   assign dac_clock_ratio = cmpc_pkg::cmpc_ratio_e'(
      state_reg.power_and_port_control_reg[`CMPC_LSB_DAC_CLOCK_RATIO +: 3]);
   assign adc_right_mute = state_reg.adc_mute_control_reg[`CMPC_BIT_ADC_RIGHT_MUTE];
   assign adc_left_mute = state_reg.adc_mute_control_reg[`CMPC_BIT_ADC_LEFT_MUTE];
   assign adc_both_mute = state_reg.adc_mute_control_reg[`CMPC_BIT_ADC_BOTH_MUTE];

   // one strobe per mapped register; writes to any other address fall away unseen
   assign wr_dac_mute_channel_select_a_power =
      i_ctrl.wr_en && i_ctrl.addr == `CMPC_ADDR_DAC_MUTE_CHANNEL_SELECT_A_POWER;
   assign wr_channel_select_a_channel_control =
      i_ctrl.wr_en && i_ctrl.addr == `CMPC_ADDR_CHANNEL_SELECT_A_CHANNEL_CONTROL;
   assign wr_power_and_port_control =
      i_ctrl.wr_en && i_ctrl.addr == `CMPC_ADDR_POWER_AND_PORT_CONTROL;
   assign wr_adc_mute_control =
      i_ctrl.wr_en && i_ctrl.addr == `CMPC_ADDR_ADC_MUTE_CONTROL;

   // global powerdown forces every channel down whatever its own disable says
   assign dac_down = {3{dac_global_powerdown}} | dac_channel_disable;

   // frame and bit lengths in master clocks, looked up per code
   // rather than divided, so no divider is built for a handful of values
   always_comb
   begin
      unique case (dac_clock_ratio)
         cmpc_pkg::CMPC_RATIO_128:
         begin
            frame_len = `CMPC_FRAME_LEN_128;
            bit_len = `CMPC_BIT_LEN_128;
         end
         cmpc_pkg::CMPC_RATIO_192:
         begin
            frame_len = `CMPC_FRAME_LEN_192;
            bit_len = `CMPC_BIT_LEN_192;
         end
         cmpc_pkg::CMPC_RATIO_256:
         begin
            frame_len = `CMPC_FRAME_LEN_256;
            bit_len = `CMPC_BIT_LEN_256;
         end
         cmpc_pkg::CMPC_RATIO_384:
         begin
            frame_len = `CMPC_FRAME_LEN_384;
            bit_len = `CMPC_BIT_LEN_384;
         end
         cmpc_pkg::CMPC_RATIO_512:
         begin
            frame_len = `CMPC_FRAME_LEN_512;
            bit_len = `CMPC_BIT_LEN_512;
         end
         cmpc_pkg::CMPC_RATIO_768:
         begin
            frame_len = `CMPC_FRAME_LEN_768;
            bit_len = `CMPC_BIT_LEN_768;
         end
         // reserved codes fall back to the reset ratio instead of stalling the port
         default:
         begin
            frame_len = `CMPC_FRAME_LEN_256;
            bit_len = `CMPC_BIT_LEN_256;
         end
      endcase
   end

   // one reinit timer per stereo channel, each counting out from its own release
   for (genvar ch = 0; ch < 3; ch++)
   begin : g_dac_channel
      // reload while the channel is down so the window is always full at release
      always_comb
      begin
         if (dac_down[ch])
            dac_reinit_next[ch] = `CMPC_REINIT_CYCLES;
         else if (state_reg.dac_reinit_cnt[ch] != 4'h0)
            dac_reinit_next[ch] = state_reg.dac_reinit_cnt[ch] - 4'h1;
         else
            dac_reinit_next[ch] = 4'h0;
      end
      // window still running after the channel came back up
      assign dac_reinit_live[ch] = state_reg.dac_reinit_cnt[ch] != 4'h0;
   end

   // next-state logic: register writes, reinit timers, clock divider, read mux
   always_comb
   begin
      state_next = state_reg;

      // registers change only on writes; powerdown never touches them
      if (wr_dac_mute_channel_select_a_power)
         state_next.dac_mute_channel_select_a_power_reg = i_ctrl.wr_data;
      if (wr_channel_select_a_channel_control)
         state_next.channel_select_a_channel_control_reg = i_ctrl.wr_data;
      if (wr_power_and_port_control)
         state_next.power_and_port_control_reg = i_ctrl.wr_data;
      if (wr_adc_mute_control)
         state_next.adc_mute_control_reg = i_ctrl.wr_data;

      // per-channel timers come from the channel loop
      state_next.dac_reinit_cnt = {dac_reinit_next[2], dac_reinit_next[1], dac_reinit_next[0]};
      if (adc_disable)
         state_next.adc_reinit_cnt = `CMPC_REINIT_CYCLES;
      else if (state_reg.adc_reinit_cnt != 4'h0)
         state_next.adc_reinit_cnt = state_reg.adc_reinit_cnt - 4'h1;

      // divider stops while not master or powered down, so clocks park low
      if (!dac_port_master_select || dac_global_powerdown)
      begin
         state_next.frame_cnt = 10'h000;
         state_next.bit_cnt = 4'h0;
         state_next.frame_clk = 1'b0;
         state_next.bit_clk = 1'b0;
      end
      else
      begin
         // a ratio change mid-frame wraps cleanly at the new length
         if (state_reg.frame_cnt >= frame_len - 10'h001)
            state_next.frame_cnt = 10'h000;
         else
            state_next.frame_cnt = state_reg.frame_cnt + 10'h001;
         if (state_reg.bit_cnt >= bit_len - 4'h1 || state_next.frame_cnt == 10'h000)
            state_next.bit_cnt = 4'h0;
         else
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
         // frame clock high for the first half of the frame
         state_next.frame_clk = state_next.frame_cnt < (frame_len >> 1);
         // bit clock falls at bit start, rises mid-bit so data settles first
         state_next.bit_clk = state_next.bit_cnt >= (bit_len >> 1);
      end

      // read-back of the addressed register; unmapped addresses read zero
      unique case (i_ctrl.addr)
         `CMPC_ADDR_DAC_MUTE_CHANNEL_SELECT_A_POWER:
            state_next.rd_data = state_reg.dac_mute_channel_select_a_power_reg;
         `CMPC_ADDR_CHANNEL_SELECT_A_CHANNEL_CONTROL:
            state_next.rd_data = state_reg.channel_select_a_channel_control_reg;
         `CMPC_ADDR_POWER_AND_PORT_CONTROL:
            state_next.rd_data = state_reg.power_and_port_control_reg;
         `CMPC_ADDR_ADC_MUTE_CONTROL:
            state_next.rd_data = state_reg.adc_mute_control_reg;
         default:
            state_next.rd_data = 9'h000;
      endcase
   end

   // state register
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg.dac_mute_channel_select_a_power_reg <= `CMPC_RST_DAC_MUTE_CHANNEL_SELECT_A_POWER;
         state_reg.channel_select_a_channel_control_reg <= `CMPC_RST_CHANNEL_SELECT_A_CHANNEL_CONTROL;
         state_reg.power_and_port_control_reg <= `CMPC_RST_POWER_AND_PORT_CONTROL;
         state_reg.adc_mute_control_reg <= `CMPC_RST_ADC_MUTE_CONTROL;
         state_reg.dac_reinit_cnt <= '0;
         state_reg.adc_reinit_cnt <= 4'h0;
         state_reg.frame_cnt <= 10'h000;
         state_reg.bit_cnt <= 4'h0;
         state_reg.frame_clk <= 1'b0;
         state_reg.bit_clk <= 1'b0;
         state_reg.rd_data <= 9'h000;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // dac controls: soft mute ramps in the filters, abrupt mute does not
   assign o_dac_soft_mute = {3{dac_global_soft_mute}} | dac_channel_soft_mute;
   assign o_dac_abrupt_mute = dac_global_powerdown;
   assign o_dac_channel_select_a = {3{channel_select_a_all_channels}} | channel_select_a;
   assign o_dac_power_down = dac_down;

   // filter reset covers the down time itself, so history is gone from the
   // first cycle off, and then the reinit window after release
   assign o_dac_filter_reset = dac_down | {dac_reinit_live[2], dac_reinit_live[1],
                                           dac_reinit_live[0]};

   // adc controls; both-mute overrides the individual bits
   assign o_adc_right_mute = adc_right_mute | adc_both_mute;
   assign o_adc_left_mute = adc_left_mute | adc_both_mute;
   assign o_adc_power_down = adc_disable;
   // filters held in reset for the whole disable, not from the cycle after it
   assign o_adc_filter_reset = adc_disable | (state_reg.adc_reinit_cnt != 4'h0);

   // the host should quiet converters first; this bit acts at once regardless
   assign o_reference_powerdown = reference_powerdown;

   // audio port pins: driven only in master mode, otherwise the source drives them
   assign o_dac_frame_clock = state_reg.frame_clk;
   assign o_dac_bit_clock = state_reg.bit_clk;
   assign o_dac_frame_clock_oe = dac_port_master_select;
   assign o_dac_bit_clock_oe = dac_port_master_select;

   // clock seen by the audio port in either role
   assign o_frame_clock_in_use = dac_port_master_select ? state_reg.frame_clk
                                                        : i_dac_frame_clock;
   assign o_bit_clock_in_use = dac_port_master_select ? state_reg.bit_clk
                                                      : i_dac_bit_clock;

   assign o_rd_data = state_reg.rd_data;

endmodule
`default_nettype wire

// ### rtl/cmpc_defines.svh
// register offsets, field positions, reset values and timing counts for the codec control bank
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH

// register addresses on the 7-bit control address
`define CMPC_ADDR_DAC_MUTE_CHANNEL_SELECT_A_POWER 7'h02
`define CMPC_ADDR_CHANNEL_SELECT_A_CHANNEL_CONTROL 7'h09
`define CMPC_ADDR_POWER_AND_PORT_CONTROL 7'h0A
`define CMPC_ADDR_ADC_MUTE_CONTROL 7'h0C

// dac_mute_channel_select_a_power fields
`define CMPC_BIT_DAC_GLOBAL_SOFT_MUTE 0
`define CMPC_BIT_CHANNEL_SELECT_A_ALL_CHANNELS 1
`define CMPC_BIT_DAC_GLOBAL_POWERDOWN 2

// channel_select_a_channel_control fields
`define CMPC_LSB_DAC_CHANNEL_SOFT_MUTE 3
`define CMPC_LSB_CHANNEL_SELECT_A 6

// power_and_port_control fields
`define CMPC_BIT_ADC_DISABLE 0
`define CMPC_LSB_DAC_CHANNEL_DISABLE 1
`define CMPC_BIT_REFERENCE_POWERDOWN 4
`define CMPC_BIT_DAC_PORT_MASTER_SELECT 5
`define CMPC_LSB_DAC_CLOCK_RATIO 6

// adc_mute_control fields
`define CMPC_BIT_ADC_RIGHT_MUTE 0
`define CMPC_BIT_ADC_LEFT_MUTE 1
`define CMPC_BIT_ADC_BOTH_MUTE 2

// reset values
`define CMPC_RST_DAC_MUTE_CHANNEL_SELECT_A_POWER 9'h000
`define CMPC_RST_CHANNEL_SELECT_A_CHANNEL_CONTROL 9'h000
`define CMPC_RST_POWER_AND_PORT_CONTROL 9'h080
`define CMPC_RST_ADC_MUTE_CONTROL 9'h000

// filter reinitialisation hold after a powerdown or disable is released
`define CMPC_REINIT_CYCLES 4'h8

// frame length in master clocks for each ratio code
`define CMPC_FRAME_LEN_128 10'h080
`define CMPC_FRAME_LEN_192 10'h0C0
`define CMPC_FRAME_LEN_256 10'h100
`define CMPC_FRAME_LEN_384 10'h180
`define CMPC_FRAME_LEN_512 10'h200
`define CMPC_FRAME_LEN_768 10'h300

// bit clock period in master clocks, 64 bit clocks to each frame
`define CMPC_BIT_LEN_128 4'h2
`define CMPC_BIT_LEN_192 4'h3
`define CMPC_BIT_LEN_256 4'h4
`define CMPC_BIT_LEN_384 4'h6
`define CMPC_BIT_LEN_512 4'h8
`define CMPC_BIT_LEN_768 4'hC

`endif

// ### rtl/cmpc_pkg.sv
// types shared by the codec mute and power control bank
package cmpc_pkg;

   typedef logic [8:0] cmpc_word_t;

   // master-clock to frame-clock ratio codes
   typedef enum logic [2:0] {
      CMPC_RATIO_128 = 3'h0,
      CMPC_RATIO_192 = 3'h1,
      CMPC_RATIO_256 = 3'h2,
      CMPC_RATIO_384 = 3'h3,
      CMPC_RATIO_512 = 3'h4,
      CMPC_RATIO_768 = 3'h5,
      CMPC_RATIO_R6 = 3'h6,
      CMPC_RATIO_R7 = 3'h7
   } cmpc_ratio_e;

   // control register write strobe with address and data
   typedef struct packed {
      logic wr_en;
      logic [6:0] addr;
      cmpc_word_t wr_data;
   } cmpc_ctrl_s;

   // whole state of the block
   typedef struct packed {
      cmpc_word_t dac_mute_channel_select_a_power_reg;
      cmpc_word_t channel_select_a_channel_control_reg;
      cmpc_word_t power_and_port_control_reg;
      cmpc_word_t adc_mute_control_reg;
      logic [2:0][3:0] dac_reinit_cnt;
      logic [3:0] adc_reinit_cnt;
      logic [9:0] frame_cnt;
      logic [3:0] bit_cnt;
      logic frame_clk;
      logic bit_clk;
      cmpc_word_t rd_data;
   } cmpc_state_s;

endpackage

// ### verification/cmpc_props.sv
// concurrent checks on the ports of the codec mute and power control bank
`timescale 1ns/10ps
`default_nettype none
module cmpc_props
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire cmpc_pkg::cmpc_ctrl_s i_ctrl,
   input wire logic [2:0] o_dac_soft_mute,
   input wire logic o_dac_abrupt_mute,
   input wire logic [2:0] o_dac_channel_select_a,
   input wire logic [2:0] o_dac_power_down,
   input wire logic [2:0] o_dac_filter_reset,
   input wire logic o_adc_left_mute,
   input wire logic o_adc_right_mute,
   input wire logic o_adc_power_down,
   input wire logic o_adc_filter_reset,
   input wire logic o_reference_powerdown,
   input wire logic i_dac_frame_clock,
   input wire logic o_dac_frame_clock,
   input wire logic o_dac_frame_clock_oe,
   input wire logic i_dac_bit_clock,
   input wire logic o_frame_clock_in_use,
   input wire logic o_bit_clock_in_use
);
   logic w02;
   logic w0a;
   logic w0c;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // write decodes; reading the strobe directly keeps them one cycle ahead of the outputs
   assign w02 = i_ctrl.wr_en && i_ctrl.addr == 7'h02;
   assign w0a = i_ctrl.wr_en && i_ctrl.addr == 7'h0A;
   assign w0c = i_ctrl.wr_en && i_ctrl.addr == 7'h0C;
   property p_soft_all;
      w02 && i_ctrl.wr_data[0] |=> o_dac_soft_mute == 3'h7;
   endproperty
   a_soft_all: assert property (p_soft_all) else $error("global soft mute not applied");
   property p_channel_select_a_all;
      w02 && i_ctrl.wr_data[1] |=> o_dac_channel_select_a == 3'h7;
   endproperty
   a_channel_select_a_all: assert property (p_channel_select_a_all) else $error("de-emphasis all not applied");
   property p_dac_global_powerdown;
      w02 && i_ctrl.wr_data[2] |=> o_dac_abrupt_mute && o_dac_power_down == 3'h7
         && o_dac_filter_reset == 3'h7;
   endproperty
   a_dac_global_powerdown: assert property (p_dac_global_powerdown) else $error("global powerdown not applied");
   property p_adc_both;
      w0c && i_ctrl.wr_data[2] |=> o_adc_left_mute && o_adc_right_mute;
   endproperty
   a_adc_both: assert property (p_adc_both) else $error("adc both mute not applied");
   property p_pwr_reg;
      w0a |=> o_adc_power_down == $past(i_ctrl.wr_data[0])
         && o_reference_powerdown == $past(i_ctrl.wr_data[4])
         && o_dac_frame_clock_oe == $past(i_ctrl.wr_data[5]);
   endproperty
   a_pwr_reg: assert property (p_pwr_reg) else $error("power control bits wrong");
   // the past-reset guard stops a mid-run reset from looking like a release
   property p_adc_reinit;
      $fell(o_adc_power_down) && !$past(i_rst) |-> o_adc_filter_reset [*8];
   endproperty
   a_adc_reinit: assert property (p_adc_reinit) else $error("adc filter reinit short");
   property p_dac_reinit;
      $fell(o_dac_power_down[1]) && !$past(i_rst) |-> o_dac_filter_reset[1] [*8];
   endproperty
   a_dac_reinit: assert property (p_dac_reinit) else $error("dac filter reinit short");
   property p_slave;
      !o_dac_frame_clock_oe |-> o_frame_clock_in_use == i_dac_frame_clock
         && o_bit_clock_in_use == i_dac_bit_clock;
   endproperty
   a_slave: assert property (p_slave) else $error("slave clocks not taken from inputs");
   // filters must sit in reset on every cycle a converter is down
   property p_down_reset;
      (o_dac_power_down & ~o_dac_filter_reset) == 3'h0
         && (!o_adc_power_down || o_adc_filter_reset);
   endproperty
   a_down_reset: assert property (p_down_reset) else $error("filter not reset while down");
   c_frame: cover property ($rose(o_dac_frame_clock));
   c_release: cover property ($fell(o_dac_power_down[1]));
   c_dac_global_powerdown: cover property (o_dac_abrupt_mute);
endmodule
`default_nettype wire

// ### verification/cmpc_top_tb.sv
// self-checking bench for the codec mute and power control bank
`timescale 1ns/10ps
`default_nettype none
module cmpc_top_tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   cmpc_pkg::cmpc_ctrl_s i_ctrl = '0;
   logic i_dac_frame_clock = 1'b0;
   logic i_dac_bit_clock = 1'b0;
   logic [8:0] o_rd_data;
   logic [2:0] o_dac_soft_mute, o_dac_channel_select_a, o_dac_power_down, o_dac_filter_reset;
   logic o_dac_abrupt_mute, o_adc_left_mute, o_adc_right_mute, o_adc_power_down;
   logic o_adc_filter_reset, o_reference_powerdown, o_dac_frame_clock, o_dac_frame_clock_oe;
   logic o_dac_bit_clock, o_dac_bit_clock_oe, o_frame_clock_in_use, o_bit_clock_in_use;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   int per[8] = '{128, 192, 256, 384, 512, 768, 256, 256};
   cmpc_top cmpc_top_i
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ctrl(i_ctrl),
      .o_rd_data(o_rd_data),
      .o_dac_soft_mute(o_dac_soft_mute),
      .o_dac_abrupt_mute(o_dac_abrupt_mute),
      .o_dac_channel_select_a(o_dac_channel_select_a),
      .o_dac_power_down(o_dac_power_down),
      .o_dac_filter_reset(o_dac_filter_reset),
      .o_adc_left_mute(o_adc_left_mute),
      .o_adc_right_mute(o_adc_right_mute),
      .o_adc_power_down(o_adc_power_down),
      .o_adc_filter_reset(o_adc_filter_reset),
      .o_reference_powerdown(o_reference_powerdown),
      .i_dac_frame_clock(i_dac_frame_clock),
      .o_dac_frame_clock(o_dac_frame_clock),
      .o_dac_frame_clock_oe(o_dac_frame_clock_oe),
      .i_dac_bit_clock(i_dac_bit_clock),
      .o_dac_bit_clock(o_dac_bit_clock),
      .o_dac_bit_clock_oe(o_dac_bit_clock_oe),
      .o_frame_clock_in_use(o_frame_clock_in_use),
      .o_bit_clock_in_use(o_bit_clock_in_use)
   );
   always #5 i_clk = ~i_clk;
   // hang guard, well above the longest clock measurement
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         test_done();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe, launched just after an edge
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(posedge i_clk);
      #1 i_ctrl = '{1'b1, a, d};
      @(posedge i_clk);
      #1 i_ctrl.wr_en = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [8:0] exp);
      @(posedge i_clk);
      #1 i_ctrl.addr = a;
      @(posedge i_clk);
      #1 cmp(o_rd_data, exp);
   endtask
   // reinit window: held now and 7 edges on, gone after the release count
   task automatic reinit(input logic [3:0] exp);
      cmp({o_adc_filter_reset, o_dac_filter_reset}, exp);
      repeat (7) @(posedge i_clk);
      #1 cmp({o_adc_filter_reset, o_dac_filter_reset}, exp);
      repeat (2) @(posedge i_clk);
      #1 cmp({o_adc_filter_reset, o_dac_filter_reset}, 4'h0);
   endtask
   // period between two rising edges of the frame (sel 0) or bit (sel 1) clock
   task automatic meas(input int sel, output int p);
      logic prev;
      logic cur;
      int k;
      p = 0;
      k = 0;
      prev = 1'b1;
      while (k < 2)
      begin
         @(posedge i_clk);
         #1 cur = sel ? o_dac_bit_clock : o_dac_frame_clock;
         if (cur && !prev)
            k++;
         if (k == 1)
            p++;
         prev = cur;
      end
   endtask
   task automatic test_done;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge i_clk);
      #1 i_rst = 1'b0;
      wr(7'h03, 9'h1FF);
      rd(7'h02, 9'h000);
      rd(7'h09, 9'h000);
      rd(7'h0A, 9'h080);
      rd(7'h0C, 9'h000);
      rd(7'h03, 9'h000);
      wr(7'h09, 9'h0A8);
      cmp(o_dac_soft_mute, 3'h5);
      cmp(o_dac_channel_select_a, 3'h2);
      wr(7'h02, 9'h001);
      cmp(o_dac_soft_mute, 3'h7);
      wr(7'h02, 9'h002);
      cmp({o_dac_soft_mute, o_dac_channel_select_a}, 6'h2F);
      for (int i = 0; i < 8; i++)
      begin
         wr(7'h0C, 9'(i));
         cmp({o_adc_left_mute, o_adc_right_mute}, {i[1] | i[2], i[0] | i[2]});
      end
      wr(7'h0A, 9'h085);
      cmp({o_adc_power_down, o_dac_power_down, o_adc_filter_reset, o_dac_filter_reset}, 8'hAA);
      wr(7'h0A, 9'h080);
      reinit(4'hA);
      wr(7'h02, 9'h004);
      cmp({o_dac_abrupt_mute, o_dac_power_down, o_dac_filter_reset}, 7'h7F);
      rd(7'h09, 9'h0A8);
      wr(7'h02, 9'h000);
      reinit(4'h7);
      wr(7'h0A, 9'h08F);
      wr(7'h0A, 9'h09F);
      cmp(o_reference_powerdown, 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         wr(7'h0A, {i[2:0], 6'h20});
         cmp({o_dac_frame_clock_oe, o_dac_bit_clock_oe}, 2'h3);
         meas(0, n);
         meas(0, n);
         cmp(n, per[i]);
         meas(1, n);
         cmp(n, per[i] / 64);
      end
      wr(7'h0A, 9'h080);
      i_dac_frame_clock = 1'b1;
      #1 cmp({o_frame_clock_in_use, o_bit_clock_in_use, o_dac_frame_clock_oe}, 3'h4);
      repeat (2) @(posedge i_clk);
      #1 cmp({o_dac_frame_clock, o_dac_bit_clock}, 2'h0);
      test_done();
   end
endmodule
bind cmpc_top cmpc_props cmpc_props_i
(
   .i_clk(i_clk),
   .i_rst(i_rst),
   .i_ctrl(i_ctrl),
   .o_dac_soft_mute(o_dac_soft_mute),
   .o_dac_abrupt_mute(o_dac_abrupt_mute),
   .o_dac_channel_select_a(o_dac_channel_select_a),
   .o_dac_power_down(o_dac_power_down),
   .o_dac_filter_reset(o_dac_filter_reset),
   .o_adc_left_mute(o_adc_left_mute),
   .o_adc_right_mute(o_adc_right_mute),
   .o_adc_power_down(o_adc_power_down),
   .o_adc_filter_reset(o_adc_filter_reset),
   .o_reference_powerdown(o_reference_powerdown),
   .i_dac_frame_clock(i_dac_frame_clock),
   .o_dac_frame_clock(o_dac_frame_clock),
   .o_dac_frame_clock_oe(o_dac_frame_clock_oe),
   .i_dac_bit_clock(i_dac_bit_clock),
   .o_frame_clock_in_use(o_frame_clock_in_use),
   .o_bit_clock_in_use(o_bit_clock_in_use)
);
`default_nettype wire
